// File: rtl/peripheral_reset_control.sv
// Peripheral reset control: two APB-writable registers whose bits hold peripherals in reset.
// Assumes an APB master on pclk; reset outputs go to peripherals on the same clock.
// Contract
// - Reset bits change only by software write or system reset and keep their value; 1 resets.
// - After system reset both reset registers read all zeros.
// - Bus-2 bit 18 resets timer sixteen while set.
// - Bus-2 bit 17 resets timer fifteen; bit 12 resets serial peripheral zero.
// - Bus-2 bit 16 resets timer fourteen; bit 14 resets serial transceiver zero.
// - Bus-2 register holds reset bits for timer zero and converter interface.
// - One bus-2 bit resets system configuration and comparator together.
// - Bus-1 bit 30 resets consumer control unit; bit 29 analog output unit.
// - Bus-1 bit 28 resets the power control unit while set.
// - Bus-1 bit 23 resets the USB device controller while set.
// - Bus-1 bit 22 resets I2C controller one while set.
// - Bus-1 bit 21 resets I2C controller zero while set.
// - Bus-1 bit 17 resets serial transceiver one while set.
// - Bus-1 bit 15 resets serial peripheral two while set.
// - Bus-1 bit 14 resets serial peripheral one while set.
// - Bus-1 bit 11 resets the window watchdog while set.
// - Bus-1 bit 8 resets timer thirteen while set.
// - Bus-1 bit 4 resets timer five while set.
// - Bus-1 bit 1 resets timer two while set.
// - Bus-1 bit 0 resets timer one while set.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps

module peripheral_reset_control
  import periph_reset_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output bus2_resets_s     bus2_resets,
  output bus1_resets_s     bus1_resets
);

  logic [31:0] bus2_q;
  logic [31:0] bus2_d;
  logic [31:0] bus1_q;
  logic [31:0] bus1_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [31:0] strb_mask;

  // Decodes an address to a known register; shared by write, read and error paths.
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    addr_hit = (a == off);
  endfunction

  wire logic access   = psel & penable;
  wire logic hit_bus2 = addr_hit(paddr, BUS2_RST_OFFSET);
  wire logic hit_bus1 = addr_hit(paddr, BUS1_RST_OFFSET);

  // Byte strobes expand to a bit mask so partial writes leave other lanes alone.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_strb
      assign strb_mask[g*8 +: 8] = {8{pstrb[g]}};
    end
  endgenerate

  // Zero wait states: every access completes in its first access cycle.
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  always_comb begin
    bus2_d    = bus2_q;
    bus1_d    = bus1_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (access && pwrite) begin
      // Only writes move the bits; reserved bits other than bus-1 bit 18 are masked off and stay zero.
      if (hit_bus2) begin
        bus2_d = ((bus2_q & ~strb_mask) | (pwdata & strb_mask)) & BUS2_RW_MASK;
      end
      if (hit_bus1) begin
        bus1_d = ((bus1_q & ~strb_mask) | (pwdata & strb_mask)) & BUS1_RW_MASK;
      end
    end
    if (psel && !penable && !pwrite) begin
      // Read data is captured in the setup cycle so it is registered by the access cycle.
      if (hit_bus2) begin
        prdata_d = bus2_q;
      end else if (hit_bus1) begin
        prdata_d = bus1_q;
      end else begin
        prdata_d = 32'h0000_0000;
      end
    end
    if (psel && !penable) begin
      pslverr_d = !(hit_bus2 || hit_bus1);
    end else if (access) begin
      pslverr_d = pslverr_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus2_q    <= RST_VALUE;
      bus1_q    <= RST_VALUE;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      bus2_q    <= bus2_d;
      bus1_q    <= bus1_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Outputs are straight wires from the register bits, so they follow the bit as a level.
  assign bus2_resets.timer_sixteen_reset        = bus2_q[B2_TIMER_SIXTEEN];
  assign bus2_resets.timer_fifteen_reset        = bus2_q[B2_TIMER_FIFTEEN];
  assign bus2_resets.serial_periph_zero_reset   = bus2_q[B2_PERIPH_ZERO];
  assign bus2_resets.timer_fourteen_reset       = bus2_q[B2_TIMER_FOURTEEN];
  assign bus2_resets.serial_xcvr_zero_reset     = bus2_q[B2_XCVR_ZERO];
  assign bus2_resets.timer_zero_reset           = bus2_q[B2_TIMER_ZERO];
  assign bus2_resets.converter_iface_reset      = bus2_q[B2_CONV_IFACE];
  assign bus2_resets.sysconfig_comparator_reset = bus2_q[B2_SYSCFG_CMP];

  assign bus1_resets.consumer_ctrl_unit_reset   = bus1_q[B1_CONSUMER_CTRL];
  assign bus1_resets.analog_output_unit_reset   = bus1_q[B1_ANALOG_OUT];
  assign bus1_resets.power_control_reset        = bus1_q[B1_POWER_CTRL];
  assign bus1_resets.usb_device_reset           = bus1_q[B1_USB_DEVICE];
  assign bus1_resets.i2c_one_reset              = bus1_q[B1_I2C_ONE];
  assign bus1_resets.i2c_zero_reset             = bus1_q[B1_I2C_ZERO];
  assign bus1_resets.serial_xcvr_one_reset      = bus1_q[B1_XCVR_ONE];
  assign bus1_resets.serial_periph_two_reset    = bus1_q[B1_PERIPH_TWO];
  assign bus1_resets.serial_periph_one_reset    = bus1_q[B1_PERIPH_ONE];
  assign bus1_resets.window_watchdog_reset      = bus1_q[B1_WWDG];
  assign bus1_resets.timer_thirteen_reset       = bus1_q[B1_TIMER_THIRTEEN];
  assign bus1_resets.timer_five_reset           = bus1_q[B1_TIMER_FIVE];
  assign bus1_resets.timer_two_reset            = bus1_q[B1_TIMER_TWO];
  assign bus1_resets.timer_one_reset            = bus1_q[B1_TIMER_ONE];

endmodule // peripheral_reset_control

// File: rtl/periph_reset_pkg.sv
// Package for the peripheral reset control block: register offsets, bit positions, masks.
// Assumes a 32-bit APB with word-aligned registers.
package periph_reset_pkg;

  localparam logic [11:0] BUS2_RST_OFFSET = 12'h00c;
  localparam logic [11:0] BUS1_RST_OFFSET = 12'h010;
  localparam logic [31:0] RST_VALUE       = 32'h0000_0000;

  // Bus-2 register bit positions.
  localparam int unsigned B2_TIMER_SIXTEEN  = 18;
  localparam int unsigned B2_TIMER_FIFTEEN  = 17;
  localparam int unsigned B2_TIMER_FOURTEEN = 16;
  localparam int unsigned B2_XCVR_ZERO      = 14;
  localparam int unsigned B2_PERIPH_ZERO    = 12;
  localparam int unsigned B2_TIMER_ZERO     = 11;
  localparam int unsigned B2_CONV_IFACE     = 9;
  localparam int unsigned B2_SYSCFG_CMP     = 0;

  // Bus-1 register bit positions.
  localparam int unsigned B1_CONSUMER_CTRL  = 30;
  localparam int unsigned B1_ANALOG_OUT     = 29;
  localparam int unsigned B1_POWER_CTRL     = 28;
  localparam int unsigned B1_USB_DEVICE     = 23;
  localparam int unsigned B1_I2C_ONE        = 22;
  localparam int unsigned B1_I2C_ZERO       = 21;
  localparam int unsigned B1_XCVR_ONE       = 17;
  localparam int unsigned B1_PERIPH_TWO     = 15;
  localparam int unsigned B1_PERIPH_ONE     = 14;
  localparam int unsigned B1_WWDG           = 11;
  localparam int unsigned B1_TIMER_THIRTEEN = 8;
  localparam int unsigned B1_TIMER_FIVE     = 4;
  localparam int unsigned B1_TIMER_TWO      = 1;
  localparam int unsigned B1_TIMER_ONE      = 0;

  // Writable bits: the implemented ones plus bus-1 bit 18, which drives no reset; other bits store nothing and read zero.
  localparam logic [31:0] BUS2_RW_MASK = 32'h0007_5a01;
  localparam logic [31:0] BUS1_RW_MASK = 32'h70e6_c913;

  typedef struct packed {
    logic timer_sixteen_reset;
    logic timer_fifteen_reset;
    logic timer_fourteen_reset;
    logic serial_xcvr_zero_reset;
    logic serial_periph_zero_reset;
    logic timer_zero_reset;
    logic converter_iface_reset;
    logic sysconfig_comparator_reset;
  } bus2_resets_s;

  typedef struct packed {
    logic consumer_ctrl_unit_reset;
    logic analog_output_unit_reset;
    logic power_control_reset;
    logic usb_device_reset;
    logic i2c_one_reset;
    logic i2c_zero_reset;
    logic serial_xcvr_one_reset;
    logic serial_periph_two_reset;
    logic serial_periph_one_reset;
    logic window_watchdog_reset;
    logic timer_thirteen_reset;
    logic timer_five_reset;
    logic timer_two_reset;
    logic timer_one_reset;
  } bus1_resets_s;

endpackage

// File: tb/peripheral_reset_chk.sv
// Checker for the peripheral reset control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module peripheral_reset_chk
  import periph_reset_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [3:0]   pstrb,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire bus2_resets_s bus2_resets,
  input wire bus1_resets_s bus1_resets
);
  function automatic bus2_resets_s m2(logic [31:0] d);
    return {d[18], d[17], d[16], d[14], d[12], d[11], d[9], d[0]};
  endfunction
  function automatic bus1_resets_s m1(logic [31:0] d);
    return {d[30], d[29], d[28], d[23], d[22], d[21], d[17], d[15], d[14], d[11], d[8],
            d[4], d[1], d[0]};
  endfunction
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr(a);
    psel && penable && pwrite && pstrb == 4'hf && paddr == a;
  endsequence
  rdy_a: assert property (pready) else $error("pready low");
  b2_wr_a: assert property (wr(12'h00c) |=> bus2_resets == m2($past(pwdata)))
    else $error("bus2 outputs wrong after write");
  b1_wr_a: assert property (wr(12'h010) |=> bus1_resets == m1($past(pwdata)))
    else $error("bus1 outputs wrong after write");
  hold_a: assert property (!(psel && penable && pwrite) |=>
    $stable(bus2_resets) && $stable(bus1_resets)) else $error("outputs moved without write");
  b2_rd_a: assert property (psel && penable && !pwrite && paddr == 12'h00c |->
    m2(prdata) == $past(bus2_resets) && (prdata & ~BUS2_RW_MASK) == 0)
    else $error("bus2 read data wrong");
  err_a: assert property (psel && penable && !(paddr inside {12'h00c, 12'h010}) |-> pslverr)
    else $error("unmapped access not flagged");
  ok_a: assert property (psel && penable && paddr inside {12'h00c, 12'h010} |-> !pslverr)
    else $error("mapped access flagged");
  rst_a: assert property ($rose(presetn) |-> bus2_resets == 0 && bus1_resets == 0)
    else $error("outputs not cleared by reset");
endmodule // peripheral_reset_chk

bind peripheral_reset_control peripheral_reset_chk chk (.*);

// File: tb/periph_model.sv
// Model of the peripherals: reports which ones are held in reset.
// Assumes the reset lines are active-high levels.
`timescale 1ns/1ps
module periph_model
  import periph_reset_pkg::*;
(
  input wire bus2_resets_s r2,
  input wire bus1_resets_s r1,
  output logic [21:0]      held
);
  assign held = {r2, r1};
endmodule // periph_model

// File: tb/tb.sv
// Testbench: APB reads and writes, checks outputs through the peripheral model.
// Assumes zero or more wait states; waits are bounded by the timeout.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  import periph_reset_pkg::*;
  logic pclk = 0, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic        pready, pslverr;
  logic [21:0] held;
  bus2_resets_s b2;
  bus1_resets_s b1;
  int num_errors = 0, total_checks = 0, cyc = 0;
  int p2[8] = '{18, 17, 16, 14, 12, 11, 9, 0};
  int p1[14] = '{30, 29, 28, 23, 22, 21, 17, 15, 14, 11, 8, 4, 1, 0};
  peripheral_reset_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus2_resets(b2), .bus1_resets(b1));
  periph_model model (.r2(b2), .r1(b1), .held(held));
  initial forever #12.5 pclk = ~pclk;
  task automatic final_report;
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk) if (++cyc > 5000) begin num_errors++; final_report; end
  // Read data and error are taken at the edge where pready is seen high, and at no other.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    forever begin
      @(posedge pclk);
      if (pready) begin
        r = prdata;
        err = pslverr;
        break;
      end
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  initial begin
    {psel, penable, pwrite, presetn} = 0; paddr = 0; pwdata = 0; pstrb = 4'hf;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h00c, 0); `CHK("bus2 reg", 32'h0, r)
    apb(0, 12'h010, 0); `CHK("bus1 reg", 32'h0, r)
    foreach (p2[i]) begin
      apb(1, 12'h00c, 32'h1 << p2[i]); `CHK("bus2 out", 22'h1 << (21 - i), held)
      apb(0, 12'h00c, 0); `CHK("bus2 rd", 32'h1 << p2[i], r)
    end
    foreach (p1[i]) begin
      apb(1, 12'h010, 32'h1 << p1[i]); `CHK("bus1 out", 22'h4000 | 22'h1 << (13 - i), held)
      apb(0, 12'h010, 0); `CHK("bus1 rd", 32'h1 << p1[i], r)
    end
    apb(1, 12'h00c, BUS2_RW_MASK); apb(1, 12'h010, BUS1_RW_MASK);
    `CHK("all out", 22'h3fffff, held)
    apb(1, 12'h014, 0); `CHK("unmapped err", 1'b1, err)
    `CHK("after unmapped", 22'h3fffff, held)
    apb(1, 12'h010, 0); `CHK("bus1 release", 22'h3fc000, held)
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    `CHK("after reset", 22'h0, held)
    final_report;
  end
endmodule // tb
